// >>> psf_cfg.svh
// Configuration constants for the standby and fail-safe sequencer
`ifndef PSF_CFG_SVH
`define PSF_CFG_SVH
// ******************************************************
// Register offsets
// ******************************************************
`define PSF_ADDR_CTRL     8'h00
`define PSF_ADDR_STATUS   8'h04
`define PSF_ADDR_CNT      8'h08
`define PSF_ADDR_IRQ      8'h0C
// ******************************************************
// Field positions
// ******************************************************
`define PSF_CTRL_LP_STBY   0
`define PSF_CTRL_PIN_EXIT  1
`define PSF_CTRL_RTRY_EXIT 2
`define PSF_CTRL_SAFE_ACT  3
`define PSF_CTRL_SAFE_DFS  4
`define PSF_CTRL_AON_MODE  5
`define PSF_CTRL_RST_AON   6
`define PSF_CTRL_VMON_EN   7
`define PSF_CTRL_WATCHDOG_ENABLE_BIT     8
`define PSF_CTRL_LIM_LSB   12
`define PSF_CTRL_WDC_LSB   16
// ******************************************************
// Reset values and timing
// ******************************************************
`define PSF_CTRL_RESET     32'h0000_0000
`define PSF_MASK_RESET     1'b1
`define PSF_CLK_MHZ        50
`define PSF_SEQ_STEP_US    10
`define PSF_SEQ_STEP_CYC   (`PSF_SEQ_STEP_US * `PSF_CLK_MHZ)
`define PSF_RETRY_MS       100
`define PSF_RETRY_CYC      (`PSF_RETRY_MS * 1000 * `PSF_CLK_MHZ)
`endif

// >>> psf_fsm.sv
// Standby, power-down, fail-safe and deep fail-safe state machine
// ******************************************************
// ******************************************************
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "psf_cfg.svh"

module psf_fsm #(
  parameter int NREG      = 4,
  parameter int RETRY_CYC = `PSF_RETRY_CYC
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  input  wire logic                  standby_req,
  input  wire logic                  power_on_pin,
  input  wire logic                  turnoff_req,
  input  wire logic                  fault_evt,
  input  wire logic                  reset_evt,
  input  wire logic                  critical_fail,
  input  wire logic                  wd_good_refresh,
  input  wire logic                  pwrup_done,
  output psf_pkg::psf_pins_type      pins,
  output psf_pkg::psf_mon_type       mon,
  output logic                       irq_out_n,
  output psf_pkg::psf_state_type     state
);
  // ******************************************************
  // Synchronisers for pins from outside
  // ******************************************************
  logic [1:0] stby_sync_ff, pon_sync_ff, toff_sync_ff;
  logic       stby_s, pon_s, toff_s, pon_prev_ff, pon_armed_ff;

  // Two flops each; only the second stage is read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stby_sync_ff <= 2'h0;
      pon_sync_ff  <= 2'h0;
      toff_sync_ff <= 2'h0;
    end else begin
      stby_sync_ff <= {stby_sync_ff[0], standby_req};
      pon_sync_ff  <= {pon_sync_ff[0], power_on_pin};
      toff_sync_ff <= {toff_sync_ff[0], turnoff_req};
    end
  end
  assign stby_s = stby_sync_ff[1];
  assign pon_s  = pon_sync_ff[1];
  assign toff_s = toff_sync_ff[1];

  // ******************************************************
  // Configuration register
  // ******************************************************
  logic [31:0] ctrl_ff;
  logic        lp_stby, pin_en, rtry_en, safe_act, safe_dfs, aon_always, rst_aon;
  logic [3:0]  fs_limit;
  logic [2:0]  wdc_limit;

  // Configuration is written whole, in any state
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      ctrl_ff <= `PSF_CTRL_RESET;
    else if (reg_wr && reg_addr == `PSF_ADDR_CTRL)
      ctrl_ff <= reg_wdata;
  end
  assign lp_stby    = ctrl_ff[`PSF_CTRL_LP_STBY];
  assign pin_en     = ctrl_ff[`PSF_CTRL_PIN_EXIT];
  assign rtry_en    = ctrl_ff[`PSF_CTRL_RTRY_EXIT];
  assign safe_act   = ctrl_ff[`PSF_CTRL_SAFE_ACT];
  assign safe_dfs   = ctrl_ff[`PSF_CTRL_SAFE_DFS];
  assign aon_always = ctrl_ff[`PSF_CTRL_AON_MODE];
  assign rst_aon    = ctrl_ff[`PSF_CTRL_RST_AON];
  assign fs_limit   = ctrl_ff[`PSF_CTRL_LIM_LSB +: 4];
  assign wdc_limit  = ctrl_ff[`PSF_CTRL_WDC_LSB +: 3];

  // ******************************************************
  // Main state machine
  // ******************************************************
  psf_pkg::psf_state_type state_ff, nxt_state;
  logic [15:0] step_cnt_ff;
  logic [$clog2(NREG+1)-1:0] reg_on_ff;
  logic [3:0]  failsafe_counter_ff;
  logic [7:0]  retry_counter_ff;
  logic [31:0] retry_tmr_ff;
  logic        step_tick, pd_done, dfs_by_count, pin_exit, retry_exit, sys_on;

  assign step_tick = step_cnt_ff == 16'(`PSF_SEQ_STEP_CYC - 1);
  assign pd_done   = reg_on_ff == '0 && step_tick;
  assign sys_on    = state_ff == psf_pkg::PSF_RUN || state_ff == psf_pkg::PSF_STBY;
  // Zero limit means counting never locks the device down
  assign dfs_by_count = fs_limit != 4'h0 && failsafe_counter_ff == fs_limit;
  assign pin_exit   = pin_en && pon_armed_ff && pon_s && !pon_prev_ff;
  assign retry_exit = rtry_en && retry_tmr_ff == 32'(RETRY_CYC - 1);

  // Next state; power-down causes are prioritised fault first
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      psf_pkg::PSF_OFF:
        if (pon_s) nxt_state = psf_pkg::PSF_PWRUP;
      psf_pkg::PSF_PWRUP:
        if (pwrup_done) nxt_state = psf_pkg::PSF_RUN;
      psf_pkg::PSF_RUN, psf_pkg::PSF_STBY: begin
        if (fault_evt)      nxt_state = psf_pkg::PSF_PD_FAULT;
        else if (reset_evt) nxt_state = psf_pkg::PSF_PD_RST;
        else if (toff_s)    nxt_state = psf_pkg::PSF_PD_OFF;
        else if (state_ff == psf_pkg::PSF_RUN && stby_s) nxt_state = psf_pkg::PSF_STBY;
        else if (state_ff == psf_pkg::PSF_STBY && !stby_s) nxt_state = psf_pkg::PSF_RUN;
      end
      psf_pkg::PSF_PD_OFF:
        if (pd_done) nxt_state = psf_pkg::PSF_OFF;
      psf_pkg::PSF_PD_FAULT:
        if (pd_done) nxt_state = psf_pkg::PSF_FAILSAFE;
      psf_pkg::PSF_PD_RST:
        if (pd_done) nxt_state = psf_pkg::PSF_PWRUP;
      psf_pkg::PSF_FAILSAFE:
        nxt_state = dfs_by_count ? psf_pkg::PSF_DFS : psf_pkg::PSF_PWRUP;
      psf_pkg::PSF_DFS:
        if (pin_exit || retry_exit) nxt_state = psf_pkg::PSF_PWRUP;
      default: nxt_state = psf_pkg::PSF_OFF;
    endcase
    if (critical_fail && state_ff != psf_pkg::PSF_DFS) nxt_state = psf_pkg::PSF_DFS;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) state_ff <= psf_pkg::PSF_OFF;
    else          state_ff <= nxt_state;
  end
  assign state = state_ff;

  // ******************************************************
  // Regulator sequencing
  // ******************************************************
  logic in_pd;
  assign in_pd = state_ff == psf_pkg::PSF_PD_OFF || state_ff == psf_pkg::PSF_PD_FAULT ||
                 state_ff == psf_pkg::PSF_PD_RST;

  // Step timer paces one regulator per step in either direction
  always_ff @(posedge ref_clk) begin
    if (!reset_n || state_ff != nxt_state || step_tick)
      step_cnt_ff <= 16'h0000;
    else if (in_pd || state_ff == psf_pkg::PSF_PWRUP)
      step_cnt_ff <= step_cnt_ff + 16'h0001;
  end

  // Regulators go off highest first in power-down and all at once in lockdown, come on lowest first
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      reg_on_ff <= '0;
    else if (state_ff == psf_pkg::PSF_DFS || state_ff == psf_pkg::PSF_FAILSAFE)
      reg_on_ff <= '0;
    else if (in_pd && step_tick && reg_on_ff != '0)
      reg_on_ff <= reg_on_ff - 1'b1;
    else if (state_ff == psf_pkg::PSF_PWRUP && step_tick && reg_on_ff != NREG[$bits(reg_on_ff)-1:0])
      reg_on_ff <= reg_on_ff + 1'b1;
  end

  // ******************************************************
  // Fail-safe and retry counters
  // ******************************************************
  logic [2:0] wd_ok_cnt_ff;

  // Host clear only in system-on states; increment wins over a clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      failsafe_counter_ff    <= 4'h0;
      wd_ok_cnt_ff <= 3'h0;
    end else if (state_ff == psf_pkg::PSF_FAILSAFE) begin
      if (!dfs_by_count) failsafe_counter_ff <= failsafe_counter_ff + 4'h1;
    end else if (sys_on && reg_wr && reg_addr == `PSF_ADDR_CNT && reg_wdata[0]) begin
      failsafe_counter_ff    <= 4'h0;
      wd_ok_cnt_ff <= 3'h0;
    end else if (sys_on && wdc_limit != 3'h0 && wd_good_refresh) begin
      if (wd_ok_cnt_ff == wdc_limit - 3'h1) begin
        failsafe_counter_ff    <= 4'h0;
        wd_ok_cnt_ff <= 3'h0;
      end else
        wd_ok_cnt_ff <= wd_ok_cnt_ff + 3'h1;
    end
  end

  // Retry timer runs only in lockdown with retry exit enabled
  always_ff @(posedge ref_clk) begin
    if (!reset_n || state_ff != psf_pkg::PSF_DFS || !rtry_en || retry_exit)
      retry_tmr_ff <= 32'h0000_0000;
    else
      retry_tmr_ff <= retry_tmr_ff + 32'h0000_0001;
  end

  // A retry in the same cycle as a host clear still counts
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      retry_counter_ff <= 8'h00;
    else if (state_ff == psf_pkg::PSF_DFS && retry_exit && !pin_exit)
      retry_counter_ff <= retry_counter_ff + 8'h01;
    else if (reg_wr && reg_addr == `PSF_ADDR_CNT && reg_wdata[1])
      retry_counter_ff <= 8'h00;
  end

  // Pin must be seen low inside lockdown before a rising edge counts
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pon_prev_ff  <= 1'b0;
      pon_armed_ff <= 1'b0;
    end else begin
      pon_prev_ff <= pon_s;
      if (state_ff != psf_pkg::PSF_DFS) pon_armed_ff <= 1'b0;
      else if (!pon_s)                  pon_armed_ff <= 1'b1;
    end
  end

  // ******************************************************
  // Interrupt flag and safety latch
  // ******************************************************
  logic irq_flag_ff, irq_mask_ff, stby_entry, fault_seen_ff;
  assign stby_entry = state_ff == psf_pkg::PSF_RUN && nxt_state == psf_pkg::PSF_STBY;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_flag_ff <= 1'b0;
      irq_mask_ff <= `PSF_MASK_RESET;
    end else begin
      if (stby_entry) irq_flag_ff <= 1'b1;
      else if (reg_wr && reg_addr == `PSF_ADDR_IRQ && reg_wdata[0]) irq_flag_ff <= 1'b0;
      if (reg_wr && reg_addr == `PSF_ADDR_IRQ) irq_mask_ff <= reg_wdata[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n)       fault_seen_ff <= 1'b0;
    else if (fault_evt) fault_seen_ff <= 1'b1;
  end

  // ******************************************************
  // Pin outputs and monitor enables
  // ******************************************************
  logic aon_keep, safe_assert;
  always_comb begin
    unique case (state_ff)
      psf_pkg::PSF_DFS:                           aon_keep = 1'b0;
      psf_pkg::PSF_PD_RST:                        aon_keep = rst_aon;
      psf_pkg::PSF_PD_OFF, psf_pkg::PSF_PD_FAULT,
      psf_pkg::PSF_FAILSAFE, psf_pkg::PSF_OFF:    aon_keep = aon_always;
      default:                                    aon_keep = 1'b1;
    endcase
    if (state_ff == psf_pkg::PSF_DFS)
      safe_assert = safe_act | safe_dfs | fault_seen_ff;
    else if (state_ff == psf_pkg::PSF_STBY)
      safe_assert = safe_act;
    else
      safe_assert = fault_seen_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pins <= '0;
      mon  <= '0;
      irq_out_n <= 1'b1;
    end else begin
      pins.power_good_out      <= sys_on;
      pins.system_reset_out_n  <= sys_on;
      pins.safety_out_n        <= !safe_assert;
      pins.always_on_regulator <= aon_keep;
      for (int i = 0; i < NREG; i++)
        pins.sys_reg_en[i] <= reg_on_ff > i[$bits(reg_on_ff)-1:0];
      mon.hf_clk_always <= state_ff == psf_pkg::PSF_RUN || (state_ff == psf_pkg::PSF_STBY && !lp_stby);
      mon.pwm_allowed   <= !(state_ff == psf_pkg::PSF_STBY && lp_stby);
      mon.vmon_run <= sys_on && !(state_ff == psf_pkg::PSF_STBY && lp_stby) && ctrl_ff[`PSF_CTRL_VMON_EN];
      mon.wdog_run <= sys_on && !(state_ff == psf_pkg::PSF_STBY && lp_stby) && ctrl_ff[`PSF_CTRL_WATCHDOG_ENABLE_BIT];
      mon.mon_run  <= sys_on && !(state_ff == psf_pkg::PSF_STBY && lp_stby);
      mon.dms_run  <= state_ff == psf_pkg::PSF_RUN;
      irq_out_n    <= !(irq_flag_ff && !irq_mask_ff);
    end
  end

  // ******************************************************
  // Register read port
  // ******************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      unique case (reg_addr)
        `PSF_ADDR_CTRL:   reg_rdata <= ctrl_ff;
        `PSF_ADDR_STATUS: reg_rdata <= {28'h0, state_ff};
        `PSF_ADDR_CNT:    reg_rdata <= {16'h0, retry_counter_ff, 4'h0, failsafe_counter_ff};
        `PSF_ADDR_IRQ:    reg_rdata <= {30'h0, irq_mask_ff, irq_flag_ff};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else
      reg_rdata <= 32'h0000_0000;
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  sequence pd_fault_s;
    state_ff == psf_pkg::PSF_PD_FAULT && pd_done;
  endsequence

  lockdown_pins_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_ff == psf_pkg::PSF_DFS |=> !pins.power_good_out && !pins.system_reset_out_n)
    else $error("power good or reset high in lockdown");
  lockdown_regs_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_ff == psf_pkg::PSF_DFS [*2] |=> pins.sys_reg_en == '0 && !pins.always_on_regulator)
    else $error("regulator on in lockdown");
  fault_path_a: assert property (@(posedge ref_clk) disable iff (!reset_n || critical_fail)
    pd_fault_s |=> state_ff == psf_pkg::PSF_FAILSAFE)
    else $error("fault power-down did not reach fail-safe");
  count_entry_a: assert property (@(posedge ref_clk) disable iff (!reset_n || critical_fail)
    state_ff == psf_pkg::PSF_FAILSAFE && fs_limit != 4'h0 && failsafe_counter_ff == fs_limit
    |=> state_ff == psf_pkg::PSF_DFS)
    else $error("counter limit did not lock down");
  zero_limit_a: assert property (@(posedge ref_clk) disable iff (!reset_n || critical_fail)
    state_ff == psf_pkg::PSF_FAILSAFE && fs_limit == 4'h0 |=> state_ff == psf_pkg::PSF_PWRUP)
    else $error("zero limit locked down");
  fs_incr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_ff == psf_pkg::PSF_FAILSAFE && !dfs_by_count |=> failsafe_counter_ff == $past(failsafe_counter_ff) + 4'h1)
    else $error("fail-safe counter did not increment");
  pin_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n || critical_fail)
    state_ff == psf_pkg::PSF_DFS && !pin_en && !rtry_en |=> state_ff == psf_pkg::PSF_DFS)
    else $error("lockdown left with exits disabled");
  irq_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stby_entry && !irq_mask_ff && !(reg_wr && reg_addr == `PSF_ADDR_IRQ) |=> ##1 !irq_out_n)
    else $error("unmasked standby entry gave no interrupt");
  retry_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_ff == psf_pkg::PSF_DFS && retry_exit && !pin_exit && !(reg_wr && reg_addr == `PSF_ADDR_CNT)
    |=> retry_counter_ff == $past(retry_counter_ff) + 8'h01)
    else $error("retry count not advanced");
endmodule

// >>> psf_host_model.sv
// Host processor model driving the standby and power-on pins
`timescale 1ns/1ns

module psf_host_model (
  input  wire logic ref_clk,
  input  wire logic stby_cmd,
  input  wire logic pwr_cmd,
  output logic      standby_req,
  output logic      power_on_pin
);
  logic [3:0] low_cnt;

  initial begin
    standby_req  = 1'b0;
    power_on_pin = 1'b0;
    low_cnt      = 4'h0;
  end

  // Pins only move just after an edge, like a host GPIO
  always @(posedge ref_clk) begin
    standby_req <= stby_cmd;
  end

  // A rise is only offered once the pin has sat low four cycles in all since start (low_cnt never clears), so it is a clean edge
  always @(posedge ref_clk) begin
    if (!pwr_cmd) begin
      power_on_pin <= 1'b0;
      low_cnt      <= (low_cnt == 4'hF) ? low_cnt : low_cnt + 4'h1;
    end else if (low_cnt >= 4'h4) begin
      power_on_pin <= 1'b1;
    end
  end
endmodule

// >>> psf_pkg.sv
// Types for the standby and fail-safe sequencer
package psf_pkg;
  typedef enum logic [3:0] {
    PSF_OFF      = 4'h0,
    PSF_RUN      = 4'h1,
    PSF_STBY     = 4'h2,
    PSF_PD_OFF   = 4'h3,
    PSF_PD_FAULT = 4'h4,
    PSF_PD_RST   = 4'h5,
    PSF_FAILSAFE = 4'h6,
    PSF_DFS      = 4'h7,
    PSF_PWRUP    = 4'h8
  } psf_state_type;

  typedef struct packed {
    logic       power_good_out;
    logic       system_reset_out_n;
    logic       safety_out_n;
    logic       always_on_regulator;
    logic [3:0] sys_reg_en;
  } psf_pins_type;

  typedef struct packed {
    logic hf_clk_always;
    logic pwm_allowed;
    logic vmon_run;
    logic wdog_run;
    logic mon_run;
    logic dms_run;
  } psf_mon_type;
endpackage

// >>> tb_top.sv
// Self-checking testbench for the standby and fail-safe sequencer
`timescale 1ns/1ns
`include "psf_cfg.svh"

module tb_top;
  localparam int RC = 20;
  logic                   ref_clk, reset_n, reg_wr, reg_rd, stby_cmd, pwr_cmd;
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, rd_val;
  logic                   standby_req, power_on_pin, turnoff_req, fault_evt;
  logic                   reset_evt, critical_fail, wd_good_refresh, pwrup_done;
  logic                   irq_out_n;
  psf_pkg::psf_pins_type  pins;
  psf_pkg::psf_mon_type   mon;
  psf_pkg::psf_state_type state;
  int                     bad_count, n_compared;

  psf_fsm #(.RETRY_CYC(RC)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .standby_req(standby_req), .power_on_pin(power_on_pin),
    .turnoff_req(turnoff_req), .fault_evt(fault_evt), .reset_evt(reset_evt),
    .critical_fail(critical_fail), .wd_good_refresh(wd_good_refresh),
    .pwrup_done(pwrup_done), .pins(pins), .mon(mon), .irq_out_n(irq_out_n),
    .state(state));

  psf_host_model i_host (.ref_clk(ref_clk), .stby_cmd(stby_cmd), .pwr_cmd(pwr_cmd),
    .standby_req(standby_req), .power_on_pin(power_on_pin));

  // ******************************************************
  // Clock, background traffic and helpers
  // ******************************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Refresh noise must not clear the counter while the clear count is zero
  always @(posedge ref_clk) begin
    wd_good_refresh <= reset_n && ($urandom_range(0, 7) == 0);
    pwrup_done      <= (pins.sys_reg_en === 4'hF);
  end

  function automatic logic [31:0] ctrl_word(input logic lp, pin, rtry, input logic [3:0] lim);
    return {13'h0, 3'h0, lim, 3'h0, 2'h3, 2'h1, 2'h0, rtry, pin, lp};
  endfunction

  function automatic logic [31:0] cnt_word(input logic [3:0] fs, input logic [7:0] rt);
    return {16'h0, rt, 4'h0, fs};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic wait_st(input psf_pkg::psf_state_type s, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (state === s) break;
    end
    check(32'(state), 32'(s));
  endtask

  task automatic fault_cycle(input psf_pkg::psf_state_type s);
    @(posedge ref_clk);
    fault_evt <= 1'b1;
    @(posedge ref_clk);
    fault_evt <= 1'b0;
    wait_st(s, 3000);
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 60000 cycles
  initial begin
    #1200000;
    bad_count++;
    $display("unexpected at %0t: run timed out", $time);
    tally_and_finish();
  end

  // ******************************************************
  // Main sequence
  // ******************************************************
  initial begin
    {reset_n, reg_wr, reg_rd, stby_cmd, pwr_cmd, turnoff_req} = 6'h00;
    {fault_evt, reset_evt, critical_fail} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    bad_count = 0;
    n_compared = 0;
    void'($urandom(32'h11f4cf6c));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`PSF_ADDR_IRQ);
    check(rd_val, 32'h2);
    rd({6'($urandom_range(4, 63)), 2'b00});
    check(rd_val, 32'h0);
    wr(`PSF_ADDR_CTRL, ctrl_word(1'b0, 1'b0, 1'b0, 4'h0));
    pwr_cmd <= 1'b1;
    wait_st(psf_pkg::PSF_RUN, 3000);
    // Monitored standby with the interrupt still masked
    stby_cmd <= 1'b1;
    wait_st(psf_pkg::PSF_STBY, 20);
    repeat (3) @(posedge ref_clk);
    check(32'({mon.hf_clk_always, mon.vmon_run, mon.wdog_run}), 32'h7);
    check(32'({mon.pwm_allowed, mon.mon_run}), 32'h3);
    check(32'(mon.dms_run), 32'h0);
    check(32'(pins), 32'hFF);
    check(32'(irq_out_n), 32'h1);
    rd(`PSF_ADDR_IRQ);
    check(rd_val, 32'h3);
    wr(`PSF_ADDR_IRQ, 32'h1);
    stby_cmd <= 1'b0;
    wait_st(psf_pkg::PSF_RUN, 20);
    // Low-power standby, unmasked: the pin must drop
    wr(`PSF_ADDR_CTRL, ctrl_word(1'b1, 1'b0, 1'b0, 4'h0));
    stby_cmd <= 1'b1;
    wait_st(psf_pkg::PSF_STBY, 20);
    repeat (3) @(posedge ref_clk);
    check(32'(irq_out_n), 32'h0);
    check(32'({mon.hf_clk_always, mon.vmon_run, mon.wdog_run, mon.mon_run}), 32'h0);
    check(32'(mon.pwm_allowed), 32'h0);
    stby_cmd <= 1'b0;
    wait_st(psf_pkg::PSF_RUN, 20);
    wr(`PSF_ADDR_IRQ, 32'h3);
    // Zero limit: a fault with counter 0 must not lock down
    fault_cycle(psf_pkg::PSF_PD_FAULT);
    repeat (3) @(posedge ref_clk);
    check(32'(pins.always_on_regulator), 32'h1);
    wait_st(psf_pkg::PSF_PWRUP, 3000);
    wait_st(psf_pkg::PSF_RUN, 3000);
    rd(`PSF_ADDR_CNT);
    check(rd_val, cnt_word(4'h1, 8'h0));
    wr(`PSF_ADDR_CTRL, ctrl_word(1'b0, 1'b1, 1'b0, 4'h2));
    fault_cycle(psf_pkg::PSF_PWRUP);
    wait_st(psf_pkg::PSF_RUN, 3000);
    rd(`PSF_ADDR_CNT);
    check(rd_val, cnt_word(4'h2, 8'h0));
    // Counter equals limit: lockdown, entered with the pin high
    fault_cycle(psf_pkg::PSF_DFS);
    repeat (3) @(posedge ref_clk);
    check(32'(pins), 32'h0);
    repeat (40) @(posedge ref_clk);
    check(32'(state), 32'(psf_pkg::PSF_DFS));
    pwr_cmd <= 1'b0;
    repeat (10) @(posedge ref_clk);
    pwr_cmd <= 1'b1;
    wait_st(psf_pkg::PSF_PWRUP, 20);
    wait_st(psf_pkg::PSF_RUN, 3000);
    // Both exits off: the pin and the timer are ignored
    wr(`PSF_ADDR_CTRL, ctrl_word(1'b0, 1'b0, 1'b0, 4'h2));
    fault_cycle(psf_pkg::PSF_DFS);
    pwr_cmd <= 1'b0;
    repeat (10) @(posedge ref_clk);
    pwr_cmd <= 1'b1;
    repeat (RC + 40) @(posedge ref_clk);
    check(32'(state), 32'(psf_pkg::PSF_DFS));
    wr(`PSF_ADDR_CTRL, ctrl_word(1'b0, 1'b0, 1'b1, 4'h2));
    wait_st(psf_pkg::PSF_PWRUP, RC + 20);
    wait_st(psf_pkg::PSF_RUN, 3000);
    rd(`PSF_ADDR_CNT);
    check(rd_val, cnt_word(4'h2, 8'h1));
    wr(`PSF_ADDR_CNT, 32'h1);
    rd(`PSF_ADDR_CNT);
    check(rd_val, cnt_word(4'h0, 8'h1));
    // Critical failure locks down from run; the timer brings it back
    @(posedge ref_clk);
    critical_fail <= 1'b1;
    @(posedge ref_clk);
    critical_fail <= 1'b0;
    wait_st(psf_pkg::PSF_DFS, 10);
    repeat (3) @(posedge ref_clk);
    check(32'(pins), 32'h0);
    wait_st(psf_pkg::PSF_PWRUP, RC + 20);
    wait_st(psf_pkg::PSF_RUN, 3000);
    // One more fault, then good refreshes with a clear count of one
    fault_cycle(psf_pkg::PSF_PWRUP);
    wait_st(psf_pkg::PSF_RUN, 3000);
    rd(`PSF_ADDR_CNT);
    check(rd_val, cnt_word(4'h1, 8'h2));
    wr(`PSF_ADDR_CTRL, ctrl_word(1'b0, 1'b0, 1'b1, 4'h2) | 32'h0001_0000);
    repeat (60) @(posedge ref_clk);
    wr(`PSF_ADDR_CNT, 32'h2);
    rd(`PSF_ADDR_CNT);
    check(rd_val, cnt_word(4'h0, 8'h0));
    // Reset event powers back up with no power-on request
    pwr_cmd <= 1'b0;
    @(posedge ref_clk);
    reset_evt <= 1'b1;
    @(posedge ref_clk);
    reset_evt <= 1'b0;
    wait_st(psf_pkg::PSF_PD_RST, 10);
    wait_st(psf_pkg::PSF_PWRUP, 3000);
    wait_st(psf_pkg::PSF_RUN, 3000);
    // Requested turn-off ends in the off state
    @(posedge ref_clk);
    turnoff_req <= 1'b1;
    wait_st(psf_pkg::PSF_PD_OFF, 10);
    repeat (3) @(posedge ref_clk);
    check(32'(pins.always_on_regulator), 32'h1);
    wait_st(psf_pkg::PSF_OFF, 3000);
    check(32'(pins.sys_reg_en), 32'h0);
    tally_and_finish();
  end
endmodule
